// File: include/tuws_pkg.sv
// constants and types for the tape unload window sequencer
package tuws_pkg;
  localparam int CLK_HZ = 10000000;
  // debounce settle time in microseconds
  localparam int DEB_US = 200;
  localparam int DEB_CYC = (DEB_US * (CLK_HZ / 1000000) > 0) ? DEB_US * (CLK_HZ / 1000000) : 1;
  localparam int DEB_W = 12;
  // tape-detected hold-off in milliseconds
  localparam int TAIL_MS = 500;
  localparam int TAIL_W = 24;
  localparam logic [TAIL_W-1:0] TAIL_CYC_DEF = TAIL_W'(TAIL_MS * (CLK_HZ / 1000));
  localparam int NIN = 11;
  localparam int IX_RESET_PB = 0;
  localparam int IX_UNLOAD_PB = 1;
  localparam int IX_LOAD_PB = 2;
  localparam int IX_RCUV = 3;
  localparam int IX_RCLV = 4;
  localparam int IX_LCLV = 5;
  localparam int IX_REELS = 6;
  localparam int IX_TAPE = 7;
  localparam int IX_UPSW = 8;
  localparam int IX_DNSW = 9;
  localparam int IX_BAIL = 10;
  localparam int IX_HUB = 11;
  localparam int IX_BOT = 12;
  localparam int NDB = 13;
  // interrupt status bits
  localparam int NIRQ = 3;
  localparam int EV_DONE = 0;
  localparam int EV_BAIL = 1;
  localparam int EV_EMPTY = 2;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ISTAT = 8'h08;
  localparam logic [7:0] A_IMASK = 8'h0c;
  localparam logic [31:0] BAD_DATA = 32'hdeadbeef;
  typedef enum logic [2:0] {
    S_IDLE, S_REWIND, S_RIGHT_OUT, S_LEFT_OUT, S_WIND, S_TAIL, S_VENT
  } tuws_state_t;
endpackage

// File: core/tuws_top.sv
// tape unload sequencer with window control and wishbone status port
//
// Summary of operation
// - reset button clears ready state
// - unload button sets flags, clears operator control
// - unload runs right reel counterclockwise
// - right upper switch drops pneumatics
// - both lower switches give columns empty
// - columns empty: valve, pneumatics, left clockwise
// - reels loaded: pneumatics off, both counterclockwise
// - reels run until tape end passes sensor
// - tape-detected delayed so right reel finishes
// - tape loss sets finished, clears in-progress
// - in-progress clear switches pneumatics off
// - window lowers after unload only below hub pressure
// - raise on load or reset, lower after unload
// - relay held, motor until up limit
// - relay dropped, motor until down limit
// - safety bail drops relay, lowers window
// - finished needs columns empty and no tape
// - rewind to marker before unloading
`timescale 1ns/1ps
module tuws_top #(
  parameter logic [tuws_pkg::TAIL_W-1:0] TAIL_CYC = tuws_pkg::TAIL_CYC_DEF
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // operator pushbuttons, high while pressed
  input wire logic RESET_PB,
  input wire logic UNLOAD_PB,
  input wire logic LOAD_PB,
  // sensors, high when transferred or active
  input wire logic RIGHT_COLUMN_UPPER_VACUUM_SWITCH,
  input wire logic RIGHT_COLUMN_LOWER_VACUUM_SWITCH,
  input wire logic LEFT_COLUMN_LOWER_VACUUM_SWITCH,
  input wire logic REELS_LOADED,
  input wire logic TAPE_SENSE,
  input wire logic AT_BOT,
  input wire logic HUB_PRESSURE_LOW,
  // window switches, high while closed; bail high when transferred
  input wire logic WINDOW_UP_SW,
  input wire logic WINDOW_DOWN_SW,
  input wire logic SAFETY_BAIL,
  // drives
  output logic READY,
  output logic OPERATOR_CONTROL,
  output logic EJECT_IN_PROGRESS,
  output logic REWIND_UNLOAD,
  output logic UNLOAD_FINISHED,
  output logic COLUMNS_EMPTY,
  output logic TAPE_DETECTED,
  output logic REWIND_DRIVE,
  output logic RIGHT_REEL_RUN,
  output logic RIGHT_REEL_CCW,
  output logic LEFT_REEL_RUN,
  output logic LEFT_REEL_CCW,
  output logic PNEUMATICS_ON,
  output logic TRANSFER_VALVE,
  output logic WINDOW_RELAY,
  output logic WINDOW_MOTOR_ON,
  // wishbone classic slave
  input wire logic WB_CYC,
  input wire logic WB_STB,
  input wire logic WB_WE,
  input wire logic [7:0] WB_ADR,
  input wire logic [3:0] WB_SEL,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK,
  output logic IRQ
);
  typedef struct packed {
    logic [tuws_pkg::NDB-1:0] s1;
    logic [tuws_pkg::NDB-1:0] s2;
    logic [tuws_pkg::NDB-1:0] db;
    logic [tuws_pkg::NDB*tuws_pkg::DEB_W-1:0] cnt;
    logic [tuws_pkg::NDB-1:0] db_d;
    tuws_pkg::tuws_state_t st;
    logic [tuws_pkg::TAIL_W-1:0] tail;
    logic ready;
    logic opctl;
    logic eject;
    logic rwu;
    logic fin;
    logic tdet;
    logic rr_run;
    logic rr_ccw;
    logic lr_run;
    logic lr_ccw;
    logic rew;
    logic pneu;
    logic valve;
    logic relay;
    logic wmot;
    logic sw_unload;
    logic sw_reset;
    logic [tuws_pkg::NIRQ-1:0] ist;
    logic [tuws_pkg::NIRQ-1:0] imask;
    logic [31:0] dato;
    logic ack;
    logic irq;
    logic cempty;
  } tuws_regs_t;

  tuws_regs_t r_reg;
  tuws_regs_t r_next;
  logic [tuws_pkg::NDB-1:0] raw;
  logic [tuws_pkg::NDB-1:0] rise;
  logic empty;
  logic wb_req;
  logic [tuws_pkg::NIRQ-1:0] ev;

  assign raw = {AT_BOT, HUB_PRESSURE_LOW, SAFETY_BAIL, WINDOW_DOWN_SW, WINDOW_UP_SW, TAPE_SENSE, REELS_LOADED,
                LEFT_COLUMN_LOWER_VACUUM_SWITCH, RIGHT_COLUMN_LOWER_VACUUM_SWITCH,
                RIGHT_COLUMN_UPPER_VACUUM_SWITCH, LOAD_PB, UNLOAD_PB, RESET_PB};
  assign rise = r_reg.db & ~r_reg.db_d;
  assign empty = r_reg.db[tuws_pkg::IX_RCLV] & r_reg.db[tuws_pkg::IX_LCLV];
  assign wb_req = WB_CYC & WB_STB & ~r_reg.ack;

  always_comb begin
    logic unload_go;
    logic reset_go;
    logic raise_go;
    unload_go = 1'b0;
    reset_go = 1'b0;
    raise_go = 1'b0;
    ev = '0;
    r_next = r_reg;
    r_next.s1 = raw;
    r_next.s2 = r_reg.s1;
    r_next.db_d = r_reg.db;
    // stable-for-settle-time filter; the second stage alone is read
    for (int i = 0; i < tuws_pkg::NDB; i++) begin
      if (r_reg.s2[i] == r_reg.db[i]) begin
        r_next.cnt[i*tuws_pkg::DEB_W +: tuws_pkg::DEB_W] = '0;
      end else if (r_reg.cnt[i*tuws_pkg::DEB_W +: tuws_pkg::DEB_W] == tuws_pkg::DEB_W'(tuws_pkg::DEB_CYC - 1)) begin
        r_next.db[i] = r_reg.s2[i];
        r_next.cnt[i*tuws_pkg::DEB_W +: tuws_pkg::DEB_W] = '0;
      end else begin
        r_next.cnt[i*tuws_pkg::DEB_W +: tuws_pkg::DEB_W] = r_reg.cnt[i*tuws_pkg::DEB_W +: tuws_pkg::DEB_W] + 1'b1;
      end
    end
    // registered copy keeps the status pin glitch free, same timing as the debounced pair
    r_next.cempty = r_next.db[tuws_pkg::IX_RCLV] & r_next.db[tuws_pkg::IX_LCLV];
    reset_go = rise[tuws_pkg::IX_RESET_PB] | r_reg.sw_reset;
    unload_go = (rise[tuws_pkg::IX_UNLOAD_PB] | r_reg.sw_unload) && r_reg.st == tuws_pkg::S_IDLE;
    raise_go = reset_go | rise[tuws_pkg::IX_LOAD_PB];
    r_next.sw_reset = 1'b0;
    r_next.sw_unload = 1'b0;
    if (reset_go) begin
      r_next.ready = 1'b0;
    end
    if (rise[tuws_pkg::IX_LOAD_PB]) begin
      r_next.ready = 1'b1;
      r_next.opctl = 1'b1;
      r_next.fin = 1'b0;
    end
    if (unload_go) begin
      r_next.eject = 1'b1;
      r_next.rwu = 1'b1;
      r_next.opctl = 1'b0;
      r_next.fin = 1'b0;
      r_next.ready = 1'b0;
      r_next.tdet = 1'b1;
      r_next.pneu = 1'b1;
      r_next.st = r_reg.db[tuws_pkg::IX_BOT] ? tuws_pkg::S_RIGHT_OUT : tuws_pkg::S_REWIND;
    end
    case (r_reg.st)
      tuws_pkg::S_IDLE: begin
        r_next.rew = 1'b0;
      end
      tuws_pkg::S_REWIND: begin
        r_next.rew = 1'b1;
        if (r_reg.db[tuws_pkg::IX_BOT]) begin
          r_next.rew = 1'b0;
          r_next.st = tuws_pkg::S_RIGHT_OUT;
        end
      end
      tuws_pkg::S_RIGHT_OUT: begin
        r_next.rr_run = 1'b1;
        r_next.rr_ccw = 1'b1;
        if (r_reg.db[tuws_pkg::IX_RCUV]) begin
          r_next.pneu = 1'b0;
        end
        if (empty) begin
          r_next.valve = 1'b1;
          r_next.pneu = 1'b1;
          r_next.rr_run = 1'b0;
          r_next.lr_run = 1'b1;
          r_next.lr_ccw = 1'b0;
          ev[tuws_pkg::EV_EMPTY] = 1'b1;
          r_next.st = tuws_pkg::S_LEFT_OUT;
        end
      end
      tuws_pkg::S_LEFT_OUT: begin
        if (r_reg.db[tuws_pkg::IX_REELS]) begin
          r_next.pneu = 1'b0;
          r_next.rr_run = 1'b1;
          r_next.rr_ccw = 1'b1;
          r_next.lr_run = 1'b1;
          r_next.lr_ccw = 1'b1;
          r_next.st = tuws_pkg::S_WIND;
        end
      end
      tuws_pkg::S_WIND: begin
        if (!r_reg.db[tuws_pkg::IX_TAPE]) begin
          r_next.tail = TAIL_CYC;
          r_next.st = tuws_pkg::S_TAIL;
        end
      end
      tuws_pkg::S_TAIL: begin
        // hold tape-detected so the right reel takes up the leader end
        if (r_reg.tail != '0) begin
          r_next.tail = r_reg.tail - 1'b1;
        end else if (empty) begin
          r_next.tdet = 1'b0;
          r_next.rr_run = 1'b0;
          r_next.lr_run = 1'b0;
          r_next.fin = 1'b1;
          r_next.eject = 1'b0;
          r_next.pneu = 1'b0;
          r_next.valve = 1'b0;
          r_next.rwu = 1'b0;
          ev[tuws_pkg::EV_DONE] = 1'b1;
          r_next.st = tuws_pkg::S_VENT;
        end
      end
      tuws_pkg::S_VENT: begin
        if (r_reg.db[tuws_pkg::IX_HUB]) begin
          r_next.relay = 1'b0;
          r_next.st = tuws_pkg::S_IDLE;
        end
      end
      default: r_next.st = tuws_pkg::S_IDLE;
    endcase
    if (raise_go) begin
      r_next.relay = 1'b1;
    end
    if (r_reg.db[tuws_pkg::IX_BAIL]) begin
      r_next.relay = 1'b0;
      ev[tuws_pkg::EV_BAIL] = rise[tuws_pkg::IX_BAIL];
    end
    // motor runs while the limit switch for the commanded direction is closed
    if (r_reg.relay) begin
      r_next.wmot = r_reg.db[tuws_pkg::IX_UPSW];
    end else begin
      r_next.wmot = r_reg.db[tuws_pkg::IX_DNSW];
    end
    // bus slave: one wait state, ack for a single cycle
    r_next.ack = wb_req;
    if (wb_req) begin
      r_next.dato = '0;
      if (WB_ADR == tuws_pkg::A_CTRL) begin
        if (WB_WE && WB_SEL[0]) begin
          r_next.sw_reset = WB_DAT_I[0];
          r_next.sw_unload = WB_DAT_I[1];
        end
      end else if (WB_ADR == tuws_pkg::A_STAT) begin
        r_next.dato = {21'h0, r_reg.st, r_reg.relay, r_reg.pneu, r_reg.tdet, empty, r_reg.fin, r_reg.rwu,
                       r_reg.eject, r_reg.ready};
      end else if (WB_ADR == tuws_pkg::A_ISTAT) begin
        if (!WB_WE) begin
          r_next.dato = {29'h0, r_reg.ist};
          r_next.ist = '0;
        end
      end else if (WB_ADR == tuws_pkg::A_IMASK) begin
        r_next.dato = {29'h0, r_reg.imask};
        if (WB_WE && WB_SEL[0]) begin
          r_next.imask = WB_DAT_I[tuws_pkg::NIRQ-1:0];
        end
      end else begin
        r_next.dato = tuws_pkg::BAD_DATA;
      end
    end
    // an event in the clearing read cycle stays set
    r_next.ist = r_next.ist | ev;
    r_next.irq = |(r_next.ist & r_next.imask);
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      r_reg <= '0;
      r_reg.st <= tuws_pkg::S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign READY = r_reg.ready;
  assign OPERATOR_CONTROL = r_reg.opctl;
  assign EJECT_IN_PROGRESS = r_reg.eject;
  assign REWIND_UNLOAD = r_reg.rwu;
  assign UNLOAD_FINISHED = r_reg.fin;
  assign COLUMNS_EMPTY = r_reg.cempty;
  assign TAPE_DETECTED = r_reg.tdet;
  assign REWIND_DRIVE = r_reg.rew;
  assign RIGHT_REEL_RUN = r_reg.rr_run;
  assign RIGHT_REEL_CCW = r_reg.rr_ccw;
  assign LEFT_REEL_RUN = r_reg.lr_run;
  assign LEFT_REEL_CCW = r_reg.lr_ccw;
  assign PNEUMATICS_ON = r_reg.pneu;
  assign TRANSFER_VALVE = r_reg.valve;
  assign WINDOW_RELAY = r_reg.relay;
  assign WINDOW_MOTOR_ON = r_reg.wmot;
  assign WB_DAT_O = r_reg.dato;
  assign WB_ACK = r_reg.ack;
  assign IRQ = r_reg.irq;

  // checks
  sequence unload_start_s;
    r_reg.st == tuws_pkg::S_IDLE && rise[tuws_pkg::IX_UNLOAD_PB];
  endsequence
  ready_clear_a: assert property (@(posedge REF_CLK) disable iff (RST)
    rise[tuws_pkg::IX_RESET_PB] && !rise[tuws_pkg::IX_LOAD_PB] |=> !READY) else $error("ready not cleared");
  unload_flags_a: assert property (@(posedge REF_CLK) disable iff (RST)
    unload_start_s |=> EJECT_IN_PROGRESS && REWIND_UNLOAD && !OPERATOR_CONTROL) else $error("unload flags wrong");
  right_out_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.st == tuws_pkg::S_RIGHT_OUT && !empty |=> RIGHT_REEL_RUN && RIGHT_REEL_CCW)
    else $error("right reel not ccw");
  pneu_drop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.st == tuws_pkg::S_RIGHT_OUT && !empty && r_reg.db[tuws_pkg::IX_RCUV] |=> !PNEUMATICS_ON)
    else $error("pneu held");
  cols_empty_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.st == tuws_pkg::S_RIGHT_OUT && empty |=> TRANSFER_VALVE && PNEUMATICS_ON && !RIGHT_REEL_RUN
    && LEFT_REEL_RUN && !LEFT_REEL_CCW) else $error("columns empty action wrong");
  reels_tight_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.st == tuws_pkg::S_LEFT_OUT && r_reg.db[tuws_pkg::IX_REELS]
    |=> !PNEUMATICS_ON && RIGHT_REEL_CCW && LEFT_REEL_CCW) else $error("reels loaded action wrong");
  finish_cond_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $rose(UNLOAD_FINISHED) |-> COLUMNS_EMPTY && !TAPE_DETECTED && !EJECT_IN_PROGRESS && !PNEUMATICS_ON)
    else $error("finish without cause");
  bail_drop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.db[tuws_pkg::IX_BAIL] |=> !WINDOW_RELAY) else $error("bail ignored");
  win_lower_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $fell(WINDOW_RELAY) && !$past(r_reg.db[tuws_pkg::IX_BAIL]) |-> $past(r_reg.db[tuws_pkg::IX_HUB]))
    else $error("window lowered early");
  tail_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.st == tuws_pkg::S_TAIL && r_reg.tail != '0 |=> TAPE_DETECTED && RIGHT_REEL_RUN && RIGHT_REEL_CCW)
    else $error("tail hold lost");
  win_up_stop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    r_reg.relay && !r_reg.db[tuws_pkg::IX_UPSW] |=> !WINDOW_MOTOR_ON) else $error("window motor past up limit");
  win_dn_stop_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !r_reg.relay && !r_reg.db[tuws_pkg::IX_DNSW] |=> !WINDOW_MOTOR_ON) else $error("window motor past down limit");
endmodule

// File: verification/tuws_plant.sv
// behavioural tape transport, column sensors, hub pressure and power window
`timescale 1ns/1ps
module tuws_plant (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // drives from the sequencer
  input wire logic rwd,
  input wire logic rr,
  input wire logic rccw,
  input wire logic lr,
  input wire logic lccw,
  input wire logic pneu,
  input wire logic relay,
  input wire logic motor,
  // sensor levels
  output logic rcuv,
  output logic lvac,
  output logic reels,
  output logic tape,
  output logic bot,
  output logic hub,
  output logic up_sw,
  output logic dn_sw
);
  logic [5:0] s;
  logic [4:0] mv_q;
  int t;
  int pos;
  assign {bot, hub, tape, reels, lvac, rcuv} = s;
  // limit switches open at the travel ends, so the motor path goes dead there
  assign up_sw = pos < 100;
  assign dn_sw = pos > 0;
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= 6'h08;
      mv_q <= 5'h00;
      t <= 0;
      pos <= 0;
    end else begin
      // t counts cycles since the reel drive pattern last changed
      mv_q <= {rwd, rr, rccw, lr, lccw};
      t <= ({rwd, rr, rccw, lr, lccw} == mv_q) ? t + 1 : 0;
      if (rwd && t > 60) s[5] <= 1'b1;
      if (rr && rccw && !lr && t > 60) s[0] <= 1'b1;
      // right lower switch only transfers once vacuum is gone
      if (s[0] && !pneu) s[1] <= 1'b1;
      if (lr && !lccw && t > 60) s[2] <= 1'b1;
      if (rr && rccw && lr && lccw && t > 60) s[3] <= 1'b0;
      // hub bleeds down slowly once everything is still and unpowered
      s[4] <= !pneu && !rr && !lr && !s[3] && t > 300;
      if (motor && relay && pos < 110) pos <= pos + 1;
      if (motor && !relay && pos > 0) pos <= pos - 1;
    end
  end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the tape unload window sequencer
`timescale 1ns/1ps
module tb_top;
  localparam int D = tuws_pkg::DEB_CYC + 20;
  logic clk = 0;
  logic rst = 1;
  logic [2:0] pb = 3'h0;
  logic bail = 0;
  logic llv = 0;
  logic [42:0] req = 43'h0;
  logic [31:0] rdat, q, m;
  logic rcuv, lvac, reels, tape, bot, hub, up_sw, dn_sw;
  logic ready, opc, eject, rwu, fin, cempty, tdet, rwd, rr, rccw, lr, lccw, pneu, tv, relay, motor, ack, irq;
  int mismatches = 0;
  int n_compared = 0;
  int seed = 99956;
  int ist_m = 0;
  int t0, cyc_n = 0;
  always #50 clk = ~clk;
  always @(posedge clk) cyc_n <= cyc_n + 1;
  tuws_top #(.TAIL_CYC(24'h14)) u_tuws_top (.REF_CLK(clk), .RST(rst),
    .RESET_PB(pb[0]), .UNLOAD_PB(pb[1]), .LOAD_PB(pb[2]),
    .RIGHT_COLUMN_UPPER_VACUUM_SWITCH(rcuv), .RIGHT_COLUMN_LOWER_VACUUM_SWITCH(lvac),
    .LEFT_COLUMN_LOWER_VACUUM_SWITCH(llv), .REELS_LOADED(reels), .TAPE_SENSE(tape), .AT_BOT(bot),
    .HUB_PRESSURE_LOW(hub), .WINDOW_UP_SW(up_sw), .WINDOW_DOWN_SW(dn_sw), .SAFETY_BAIL(bail),
    .READY(ready), .OPERATOR_CONTROL(opc), .EJECT_IN_PROGRESS(eject), .REWIND_UNLOAD(rwu),
    .UNLOAD_FINISHED(fin), .COLUMNS_EMPTY(cempty), .TAPE_DETECTED(tdet), .REWIND_DRIVE(rwd),
    .RIGHT_REEL_RUN(rr), .RIGHT_REEL_CCW(rccw), .LEFT_REEL_RUN(lr), .LEFT_REEL_CCW(lccw),
    .PNEUMATICS_ON(pneu), .TRANSFER_VALVE(tv), .WINDOW_RELAY(relay), .WINDOW_MOTOR_ON(motor),
    .WB_CYC(req[42]), .WB_STB(req[41]), .WB_WE(req[40]), .WB_ADR(req[39:32]), .WB_SEL(4'hf),
    .WB_DAT_I(req[31:0]), .WB_DAT_O(rdat), .WB_ACK(ack), .IRQ(irq));
  tuws_plant u_tuws_plant (.clk(clk), .rst(rst), .rwd(rwd), .rr(rr), .rccw(rccw), .lr(lr), .lccw(lccw),
    .pneu(pneu), .relay(relay), .motor(motor), .rcuv(rcuv), .lvac(lvac), .reels(reels), .tape(tape),
    .bot(bot), .hub(hub), .up_sw(up_sw), .dn_sw(dn_sw));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= {2'b11, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) chk(n, 0);
    req <= 43'h0;
  endtask
  // button level held long enough to pass the debounce
  task automatic press(input int i, input logic v);
    @(posedge clk);
    pb[i] <= v;
    repeat (D) @(posedge clk);
  endtask
  task automatic await(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 30000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 30000) chk(s, v);
  endtask
  task automatic rd_ist;
    wb(1'b0, tuws_pkg::A_ISTAT, 32'h0);
    chk(q[2:0], ist_m);
    ist_m = 0;
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({ready, eject, relay, pneu, rr, lr, irq}, 0);
    m = $random(seed);
    wb(1'b1, tuws_pkg::A_IMASK, m);
    wb(1'b0, tuws_pkg::A_IMASK, 32'h0);
    chk(q[2:0], m[2:0]);
    wb(1'b1, tuws_pkg::A_IMASK, 32'h7);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, tuws_pkg::BAD_DATA);
    press(2, 1'b1);
    press(2, 1'b0);
    chk({ready, relay}, 2'b11);
    await(up_sw, 1'b0);
    await(motor, 1'b0);
    chk({relay, up_sw}, 2'b10);
    press(0, 1'b1);
    chk(ready, 0);
    press(0, 1'b0);
    press(1, 1'b1);
    chk({eject, rwu, opc, rwd, rr}, 5'b11010);
    press(1, 1'b0);
    await(rr, 1'b1);
    chk({rr, rccw, lr}, 3'b110);
    await(rcuv, 1'b1);
    repeat (D) @(posedge clk);
    chk({pneu, cempty}, 0);
    repeat (D) @(posedge clk);
    chk({cempty, lr}, 0);
    llv <= 1'b1;
    await(lr, 1'b1);
    chk({cempty, tv, pneu, rr, lccw}, 5'b11100);
    ist_m |= 1 << tuws_pkg::EV_EMPTY;
    chk(irq, 1);
    rd_ist;
    repeat (2) @(posedge clk);
    chk(irq, 0);
    await(lccw, 1'b1);
    repeat (2) @(posedge clk);
    chk({rr, rccw, lr, pneu}, 4'b1110);
    await(tape, 1'b0);
    t0 = cyc_n;
    repeat (D - 10) @(posedge clk);
    chk({rr, tdet, fin}, 3'b110);
    await(tdet, 1'b0);
    chk(cyc_n - t0 >= tuws_pkg::DEB_CYC + 20, 1);
    repeat (2) @(posedge clk);
    chk({fin, eject, cempty, rr, lr, pneu, relay}, 7'b1010001);
    ist_m |= 1 << tuws_pkg::EV_DONE;
    await(relay, 1'b0);
    chk(hub, 1);
    repeat (3) @(posedge clk);
    chk(motor, 1);
    await(dn_sw, 1'b0);
    await(motor, 1'b0);
    chk({relay, dn_sw}, 0);
    rd_ist;
    press(2, 1'b1);
    press(2, 1'b0);
    chk(relay, 1);
    wb(1'b1, tuws_pkg::A_IMASK, 32'h0);
    @(posedge clk);
    bail <= 1'b1;
    repeat (D) @(posedge clk);
    chk({relay, motor, irq}, 3'b010);
    ist_m |= 1 << tuws_pkg::EV_BAIL;
    wb(1'b1, tuws_pkg::A_IMASK, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    rd_ist;
    bail <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq, 0);
    repeat (D) @(posedge clk);
    wb(1'b1, tuws_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    wb(1'b0, tuws_pkg::A_STAT, 32'h0);
    chk(q, 32'h90);
    complete_run;
  end
endmodule
